// File: inc/clk_sleep_pkg.sv
// Constants, register map and carrier types for the clock source and sleep control block.
// Assumes a 32-bit APB slave where each register index maps to byte address index*4.
package clk_sleep_pkg;

  // Register indices; the byte address is the index times four.
  localparam logic [9:0] POWER_CONTROL_IDX       = 10'h087;
  localparam logic [9:0] EXT_FLAG_CLOCK_CTRL_IDX = 10'h091;
  localparam logic [9:0] POWER_MODE_CONTROL_IDX  = 10'h0C4;
  localparam logic [9:0] CLOCK_IRQ_STATUS_IDX    = 10'h0C5;

  // Field positions.
  localparam int IDLE_BIT         = 0;
  localparam int STOP_BIT         = 1;
  localparam int BANDGAP_BIT      = 0;
  localparam int RING_START_BIT   = 1;
  localparam int RING_ACTIVE_BIT  = 2;
  localparam int CLK_SRC_BIT      = 3;
  localparam int XTAL_OFF_BIT     = 3;
  localparam int SWB_BIT          = 5;
  localparam int CDIV_LSB         = 6;
  localparam int XTAL_READY_BIT   = 4;

  // Values after reset.
  localparam logic       CLK_SRC_RESET    = 1'b1;
  localparam logic       XTAL_READY_RESET = 1'b1;
  localparam logic [1:0] CDIV_RESET       = 2'h1;

  // Cycle divider codes and the last count of each instruction cycle.
  localparam logic [1:0] CDIV_RESERVED = 2'h0;
  localparam logic [1:0] CDIV_BY4      = 2'h1;
  localparam logic [1:0] CDIV_BY64     = 2'h2;
  localparam logic [1:0] CDIV_BY1024   = 2'h3;
  localparam logic [9:0] LAST_BY4      = 10'h003;
  localparam logic [9:0] LAST_BY64     = 10'h03F;
  localparam logic [9:0] LAST_BY1024   = 10'h3FF;

  // Crystal warm-up length in crystal clocks.
  localparam int WARMUP_CLOCKS = 65536;

  typedef enum logic [3:0] {
    SLP_RUN       = 4'b0001,
    SLP_IDLE      = 4'b0010,
    SLP_STOP      = 4'b0100,
    SLP_WAIT_XTAL = 4'b1000
  } sleep_state_e;

  typedef struct packed {
    logic powerfailIrqInService;
    logic highIrqInService;
    logic lowIrqInService;
    logic port1TxActive;
    logic port1RxActive;
    logic port0TxActive;
    logic port0RxActive;
  } status_in_s;

  typedef struct packed {
    logic anyIrq;
    logic extIrq;
    logic rtcIrq;
    logic powerfailInterrupt;
  } wake_in_s;

endpackage : clk_sleep_pkg

// File: src/clock_source_and_sleep_control.sv
// Clock source selection, crystal warm-up, cycle divider and Idle/Stop control with an APB register slave.
// Assumes crystal and ring clocks arrive as one-cycle tick pulses synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - After reset the CPU runs from the crystal, never the ring.
// - Clock source select one picks crystal, zero picks ring.
// - Ring-active flag reads one on ring, zero on crystal; resets to zero.
// - Amplifier disable may be set only while the ring is selected.
// - Source changes take effect at the next instruction cycle boundary with crystal running.
// - Clearing amplifier disable restarts the crystal; ready flag sets after warm-up.
// - Warm-up lasts 65,536 crystal clocks.
// - Selecting the crystal needs ready flag one and amplifier enabled.
// - Switchback restores only the divider, never the clock source.
// - Crystal-ready flag resets to one and is read-only.
// - Divider resets to 4 clocks; 64 or 1024 only from 4 clocks.
// - With switchback enabled, a qualifying event returns the divider to 4 clocks.
// - Status bits 7 to 5 show power-fail, high and low interrupt service.
// - Status bits 3 to 0 show serial transmit and receive activity.
// - Power control bit 0 enters Idle; CPU halts, peripherals run; interrupts end it.
// - Power control bit 1 enters Stop; all clocks halt; external interrupt ends it.
// - A real-time-clock interrupt also ends Stop.
// - Band-gap bit keeps the reference on in Stop only.
// - With band-gap kept on, power-fail interrupt can wake from Stop.
// - Ring-start bit runs the CPU from the ring on Stop exit, as does a disabled amplifier; else waits for crystal.
// - After a ring start, hardware moves to the crystal once warm-up ends.
module clock_source_and_sleep_control #(
  parameter int WARMUP_CLOCKS = clk_sleep_pkg::WARMUP_CLOCKS
) (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      xtalTick,
  input  wire logic                      ringTick,
  input  wire clk_sleep_pkg::status_in_s statusIn,
  input  wire clk_sleep_pkg::wake_in_s   wakeIn,
  input  wire logic                      switchbackEvent,
  output logic                           cpuClkEn,
  output logic                           periphClkEn,
  output logic                           instrCycleEn,
  output logic                           crystalAmpEnable,
  output logic                           bandgapEnable,
  output logic                           sleepIdle,
  output logic                           sleepStop
);

  function automatic logic regHit(input logic [11:0] addr, input logic [9:0] idx);
    regHit = (addr == {idx, 2'b00});
  endfunction : regHit

  function automatic logic [9:0] lastCount(input logic [1:0] code);
    unique case (code)
      clk_sleep_pkg::CDIV_BY64:   lastCount = clk_sleep_pkg::LAST_BY64;
      clk_sleep_pkg::CDIV_BY1024: lastCount = clk_sleep_pkg::LAST_BY1024;
      default:                    lastCount = clk_sleep_pkg::LAST_BY4;
    endcase
  endfunction : lastCount

  clk_sleep_pkg::sleep_state_e state_q;
  logic        clkSel_q;
  logic        ringActive_q;
  logic        xtalOff_q;
  logic        xtalReady_q;
  logic [16:0] warmCnt_q;
  logic        autoBack_q;
  logic [1:0]  cdiv_q;
  logic [1:0]  divEff_q;
  logic        swb_q;
  logic        bgs_q;
  logic        ring_start_on_stop_exit_q;
  logic [9:0]  cycCnt_q;
  logic [31:0] prdata_q;

  logic hitPcon;
  logic hitExif;
  logic hitPmr;
  logic hitStatus;
  logic apbSetup;
  logic apbWrite;
  logic wrPcon;
  logic wrExif;
  logic wrPmr;
  logic inRun;
  logic inIdle;
  logic inStop;
  logic inWait;
  logic srcTick;
  logic crystalRunning;
  logic warmDone;
  logic stopWake;
  logic enterStop;
  logic enterIdle;
  logic [1:0] cdivWr;

  assign hitPcon   = regHit(paddr, clk_sleep_pkg::POWER_CONTROL_IDX);
  assign hitExif   = regHit(paddr, clk_sleep_pkg::EXT_FLAG_CLOCK_CTRL_IDX);
  assign hitPmr    = regHit(paddr, clk_sleep_pkg::POWER_MODE_CONTROL_IDX);
  assign hitStatus = regHit(paddr, clk_sleep_pkg::CLOCK_IRQ_STATUS_IDX);
  assign apbSetup  = psel & ~penable;
  assign apbWrite  = psel & penable & pwrite;
  assign wrPcon    = apbWrite & hitPcon;
  assign wrExif    = apbWrite & hitExif;
  assign wrPmr     = apbWrite & hitPmr;
  assign cdivWr    = pwdata[clk_sleep_pkg::CDIV_LSB +: 2];

  // Zero wait states; an unmapped address is refused with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hitPcon | hitExif | hitPmr | hitStatus);
  assign prdata  = prdata_q;

  assign inRun  = (state_q == clk_sleep_pkg::SLP_RUN);
  assign inIdle = (state_q == clk_sleep_pkg::SLP_IDLE);
  assign inStop = (state_q == clk_sleep_pkg::SLP_STOP);
  assign inWait = (state_q == clk_sleep_pkg::SLP_WAIT_XTAL);

  // Ticks are whole one-cycle pulses and the source only flips on a tick of the old one or while leaving Stop,
  // so the CPU never sees a shortened clock.
  assign srcTick      = ringActive_q ? ringTick : xtalTick;
  assign cpuClkEn     = srcTick & inRun;
  assign periphClkEn  = srcTick & (inRun | inIdle);
  assign instrCycleEn = periphClkEn & (cycCnt_q == lastCount(divEff_q));

  assign crystalRunning   = ~xtalOff_q & ~inStop;
  assign crystalAmpEnable = crystalRunning;
  assign bandgapEnable    = ~inStop | bgs_q;
  assign sleepIdle        = inIdle;
  assign sleepStop        = inStop;

  assign warmDone  = crystalRunning & ~xtalReady_q & xtalTick
                   & (warmCnt_q == 17'(WARMUP_CLOCKS - 1));
  // Internal interrupts cannot wake Stop; the RTC and a band-gap backed power-fail can.
  assign stopWake  = wakeIn.extIrq | wakeIn.rtcIrq | (bgs_q & wakeIn.powerfailInterrupt);
  assign enterStop = wrPcon & pwdata[clk_sleep_pkg::STOP_BIT] & inRun;
  assign enterIdle = wrPcon & pwdata[clk_sleep_pkg::IDLE_BIT] & ~pwdata[clk_sleep_pkg::STOP_BIT] & inRun;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= clk_sleep_pkg::SLP_RUN;
    end else begin
      unique case (state_q)
        clk_sleep_pkg::SLP_RUN: begin
          if (enterStop) begin
            state_q <= clk_sleep_pkg::SLP_STOP;
          end else if (enterIdle) begin
            state_q <= clk_sleep_pkg::SLP_IDLE;
          end
        end
        clk_sleep_pkg::SLP_IDLE: begin
          if (wakeIn.anyIrq | wakeIn.extIrq | wakeIn.rtcIrq | wakeIn.powerfailInterrupt) begin
            state_q <= clk_sleep_pkg::SLP_RUN;
          end
        end
        clk_sleep_pkg::SLP_STOP: begin
          if (stopWake) begin
            state_q <= (ring_start_on_stop_exit_q | xtalOff_q) ? clk_sleep_pkg::SLP_RUN
                                            : clk_sleep_pkg::SLP_WAIT_XTAL;
          end
        end
        clk_sleep_pkg::SLP_WAIT_XTAL: begin
          if (xtalReady_q) begin
            state_q <= clk_sleep_pkg::SLP_RUN;
          end
        end
        default: state_q <= clk_sleep_pkg::SLP_RUN;
      endcase
    end
  end

  // Source select and the active-source flag.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      clkSel_q     <= clk_sleep_pkg::CLK_SRC_RESET;
      ringActive_q <= 1'b0;
      autoBack_q   <= 1'b0;
    end else begin
      if (inStop & stopWake & (ring_start_on_stop_exit_q | xtalOff_q)) begin
        clkSel_q     <= 1'b0;
        ringActive_q <= 1'b1;
        autoBack_q   <= ring_start_on_stop_exit_q & ~xtalOff_q;
      end else begin
        if (autoBack_q & xtalReady_q & inRun) begin
          clkSel_q   <= 1'b1;
          autoBack_q <= 1'b0;
        end else if (wrExif) begin
          if (!pwdata[clk_sleep_pkg::CLK_SRC_BIT]) begin
            clkSel_q <= 1'b0;
          end else if (xtalReady_q & ~xtalOff_q) begin
            clkSel_q <= 1'b1;
          end
        end
        if (enterStop) begin
          autoBack_q <= 1'b0;
        end
        // The flip waits for an instruction cycle boundary and needs the crystal alive.
        if (instrCycleEn & crystalRunning) begin
          ringActive_q <= ~clkSel_q;
        end
      end
    end
  end

  // Crystal amplifier, warm-up counter and ready flag.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      xtalOff_q   <= 1'b0;
      xtalReady_q <= clk_sleep_pkg::XTAL_READY_RESET;
      warmCnt_q   <= '0;
    end else begin
      if (wrPmr) begin
        if (!pwdata[clk_sleep_pkg::XTAL_OFF_BIT]) begin
          xtalOff_q <= 1'b0;
        end else if (!clkSel_q) begin
          xtalOff_q <= 1'b1;
        end
      end
      if (!crystalRunning || xtalReady_q) begin
        warmCnt_q <= '0;
      end else if (xtalTick) begin
        warmCnt_q <= warmCnt_q + 17'h00001;
      end
      // A finished warm-up wins over a clear in the same cycle.
      if (warmDone) begin
        xtalReady_q <= 1'b1;
      end else if ((wrPmr & pwdata[clk_sleep_pkg::XTAL_OFF_BIT] & ~clkSel_q) | enterStop) begin
        xtalReady_q <= 1'b0;
      end
    end
  end

  // Cycle divider, its delayed effective copy and switchback.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cdiv_q   <= clk_sleep_pkg::CDIV_RESET;
      divEff_q <= clk_sleep_pkg::CDIV_RESET;
      swb_q    <= 1'b0;
      cycCnt_q <= '0;
    end else begin
      if (wrPmr) begin
        swb_q <= pwdata[clk_sleep_pkg::SWB_BIT];
      end
      // Switchback touches only the divider, so a ring time base stays selected.
      if (swb_q & switchbackEvent) begin
        cdiv_q <= clk_sleep_pkg::CDIV_BY4;
      end else if (wrPmr) begin
        if (cdivWr == clk_sleep_pkg::CDIV_BY4) begin
          cdiv_q <= cdivWr;
        end else if (cdivWr != clk_sleep_pkg::CDIV_RESERVED && cdiv_q == clk_sleep_pkg::CDIV_BY4) begin
          cdiv_q <= cdivWr;
        end
      end
      if (instrCycleEn) begin
        divEff_q <= cdiv_q;
        cycCnt_q <= '0;
      end else if (periphClkEn) begin
        cycCnt_q <= cycCnt_q + 10'h001;
      end
    end
  end

  // Stop options.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bgs_q  <= 1'b0;
      ring_start_on_stop_exit_q <= 1'b0;
    end else if (wrExif) begin
      bgs_q  <= pwdata[clk_sleep_pkg::BANDGAP_BIT];
      ring_start_on_stop_exit_q <= pwdata[clk_sleep_pkg::RING_START_BIT];
    end
  end

  // Read data is captured in the setup phase and held through the access phase.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prdata_q <= '0;
    end else if (apbSetup) begin
      prdata_q <= '0;
      if (hitPcon) begin
        prdata_q[clk_sleep_pkg::IDLE_BIT] <= inIdle;
        prdata_q[clk_sleep_pkg::STOP_BIT] <= inStop;
      end else if (hitExif) begin
        prdata_q[clk_sleep_pkg::CLK_SRC_BIT]     <= clkSel_q;
        prdata_q[clk_sleep_pkg::RING_ACTIVE_BIT] <= ringActive_q;
        prdata_q[clk_sleep_pkg::RING_START_BIT]  <= ring_start_on_stop_exit_q;
        prdata_q[clk_sleep_pkg::BANDGAP_BIT]     <= bgs_q;
      end else if (hitPmr) begin
        prdata_q[clk_sleep_pkg::CDIV_LSB +: 2]   <= cdiv_q;
        prdata_q[clk_sleep_pkg::SWB_BIT]         <= swb_q;
        prdata_q[clk_sleep_pkg::XTAL_OFF_BIT]    <= xtalOff_q;
      end else if (hitStatus) begin
        prdata_q[7:0] <= {statusIn[6:4], xtalReady_q, statusIn[3:0]};
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // The reset check must run while reset is low, so it opts out of the default disable.
  reset_crystal_a: assert property (disable iff (1'b0) !nrst |=> clkSel_q && !ringActive_q && xtalReady_q)
    else $error("reset did not select crystal");
  source_follow_a: assert property (instrCycleEn && crystalRunning && !(inStop && stopWake)
                                    |=> ringActive_q != $past(clkSel_q))
    else $error("active source did not follow select");
  ring_tick_a: assert property (cpuClkEn && ringActive_q |-> ringTick)
    else $error("ring flag set but CPU not on ring ticks");
  amp_guard_a: assert property ($rose(xtalOff_q) |-> !$past(clkSel_q))
    else $error("amplifier disabled while crystal selected");
  source_hold_a: assert property ($changed(ringActive_q) && !$past(inStop) |-> $past(instrCycleEn))
    else $error("source changed off a cycle boundary");
  ready_count_a: assert property ($rose(xtalReady_q) |-> $past(warmCnt_q) == 17'(WARMUP_CLOCKS - 1))
    else $error("crystal ready before full warm-up");
  select_guard_a: assert property ($rose(clkSel_q) |-> $past(xtalReady_q) && !$past(xtalOff_q))
    else $error("crystal selected before ready");
  switchback_only_a: assert property (swb_q && switchbackEvent && !wrExif && !(inStop && stopWake)
                                      && !(autoBack_q && xtalReady_q)
                                      |=> cdiv_q == clk_sleep_pkg::CDIV_BY4 && $stable(clkSel_q))
    else $error("switchback wrong");
  divider_guard_a: assert property ($changed(cdiv_q) && cdiv_q[1] |-> $past(cdiv_q) == clk_sleep_pkg::CDIV_BY4)
    else $error("slow divider entered from a slow divider");
  ready_clear_a: assert property (wrPmr && pwdata[clk_sleep_pkg::XTAL_OFF_BIT] && !clkSel_q && !warmDone
                                  |=> !xtalReady_q)
    else $error("ready flag survived amplifier disable");
  idle_enter_a: assert property (enterIdle |=> inIdle ##0 !cpuClkEn)
    else $error("Idle not entered");
  stop_clock_a: assert property (enterStop |=> (!periphClkEn && !crystalAmpEnable) [*2])
    else $error("clocks ran in Stop");
  stop_wake_a: assert property (inStop && (wakeIn.extIrq || wakeIn.rtcIrq) |=> !inStop)
    else $error("Stop not left on wake");
  bandgap_wake_a: assert property (inStop && !bgs_q && !wakeIn.extIrq && !wakeIn.rtcIrq |=> inStop)
    else $error("woke from Stop without a valid source");
  ring_start_a: assert property (inStop && stopWake && ring_start_on_stop_exit_q |=> inRun && ringActive_q && !clkSel_q)
    else $error("ring start on Stop exit failed");
  wait_xtal_a: assert property (inWait && !xtalReady_q |-> !cpuClkEn)
    else $error("CPU ran before crystal was ready");
  auto_back_a: assert property (autoBack_q && xtalReady_q && inRun && !enterStop |=> clkSel_q)
    else $error("no automatic return to crystal");
  status_read_a: assert property (apbSetup && hitStatus |=> prdata[4] == $past(xtalReady_q)
                                  && {prdata[7:5], prdata[3:0]} == $past(statusIn))
    else $error("status read mismatch");
  idle_wake_a: assert property (inIdle && wakeIn.anyIrq |=> inRun)
    else $error("Idle not left on interrupt");
  reserved_div_a: assert property (cdiv_q != clk_sleep_pkg::CDIV_RESERVED)
    else $error("divider holds the reserved code");

  idle_cycle_c: cover property (enterIdle ##[1:20] inRun);
  ring_wake_c: cover property (inStop && stopWake && ring_start_on_stop_exit_q);
  xtal_wait_c: cover property (inWait ##1 inRun);
  switchback_c: cover property (swb_q && switchbackEvent && cdiv_q != clk_sleep_pkg::CDIV_BY4);
  auto_back_c: cover property (autoBack_q && xtalReady_q && inRun);

endmodule : clock_source_and_sleep_control

`default_nettype wire

// File: verification/test_clock_source_and_sleep_control.sv
// Self-checking bench for the clock source and sleep control block.
// Assumes zero-wait APB answers and that the design carries its own assertions.
`timescale 1ns/100ps
`default_nettype none
module test_clock_source_and_sleep_control;
  // A short warm-up keeps every crystal wait down to a few dozen core cycles.
  localparam int          WARM   = 16;
  localparam logic [11:0] PWR_A  = {clk_sleep_pkg::POWER_CONTROL_IDX, 2'h0};
  localparam logic [11:0] EXT_A  = {clk_sleep_pkg::EXT_FLAG_CLOCK_CTRL_IDX, 2'h0};
  localparam logic [11:0] MODE_A = {clk_sleep_pkg::POWER_MODE_CONTROL_IDX, 2'h0};
  localparam logic [11:0] STAT_A = {clk_sleep_pkg::CLOCK_IRQ_STATUS_IDX, 2'h0};

  logic                      core_clk;
  logic                      nrst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      xtalTick;
  logic                      ringTick;
  logic                      switchbackEvent;
  logic                      cpuClkEn;
  logic                      periphClkEn;
  logic                      instrCycleEn;
  logic                      crystalAmpEnable;
  logic                      bandgapEnable;
  logic                      sleepIdle;
  logic                      sleepStop;
  clk_sleep_pkg::status_in_s statusIn;
  clk_sleep_pkg::wake_in_s   wakeIn;
  int                        nErrors;
  int                        checks;
  int                        ringPhase;
  logic [31:0]               rd;
  logic                      err;
  int                        c;
  int                        p;
  int                        ic;
  // Status inputs beside the status byte that each should read back as.
  logic [6:0]                stIn [4] = '{7'h7F, 7'h40, 7'h15, 7'h0A};
  logic [31:0]               stExp [4] = '{32'hFF, 32'h90, 32'h35, 32'h1A};

  clock_source_and_sleep_control #(.WARMUP_CLOCKS(WARM)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtalTick(xtalTick), .ringTick(ringTick), .statusIn(statusIn), .wakeIn(wakeIn),
    .switchbackEvent(switchbackEvent), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .instrCycleEn(instrCycleEn), .crystalAmpEnable(crystalAmpEnable),
    .bandgapEnable(bandgapEnable), .sleepIdle(sleepIdle), .sleepStop(sleepStop)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Crystal ticks every second cycle, ring ticks every third, so counts tell the sources apart.
  always @(posedge core_clk) begin
    xtalTick <= ~xtalTick;
    ringTick <= (ringPhase == 2);
    ringPhase <= (ringPhase == 2) ? 0 : ringPhase + 1;
  end

  task automatic endSim;
    if (nErrors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : endSim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) nErrors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask : rdc

  task automatic cnt(output int cc, output int pc);
    cc = 0;
    pc = 0;
    ic = 0;
    repeat (12) begin
      @(negedge core_clk);
      cc += (cpuClkEn === 1'b1);
      pc += (periphClkEn === 1'b1);
      ic += (instrCycleEn === 1'b1);
    end
  endtask : cnt

  task automatic wake(input logic [3:0] w);
    @(posedge core_clk);
    wakeIn <= w;
    @(posedge core_clk);
    wakeIn <= 4'h0;
    repeat (2) @(negedge core_clk);
  endtask : wake

  task automatic pulse;
    @(posedge core_clk);
    switchbackEvent <= 1'b1;
    @(posedge core_clk);
    switchbackEvent <= 1'b0;
  endtask : pulse

  task automatic doReset;
    @(posedge core_clk);
    nrst <= 1'b0;
    statusIn <= 7'h00;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : doReset

  task automatic resetChk;
    rdc("ext reset", EXT_A, 32'h08);
    rdc("mode reset", MODE_A, 32'h40);
    rdc("status reset", STAT_A, 32'h10);
    rdc("power reset", PWR_A, 32'h00);
    chk("bandgap run", bandgapEnable, 1'b1);
    chk("amp run", crystalAmpEnable, 1'b1);
  endtask : resetChk

  initial begin
    nErrors = 0;
    checks = 0;
    ringPhase = 0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {xtalTick, ringTick, switchbackEvent} = '0;
    statusIn = 7'h00;
    wakeIn = 4'h0;
    doReset;
    resetChk;
    for (int i = 0; i < 4; i++) begin
      statusIn <= stIn[i];
      rdc("status row", STAT_A, stExp[i]);
    end
    statusIn <= 7'h00;
    wr(STAT_A, 32'h00);
    rdc("status ro", STAT_A, 32'h10);
    apb(1'b0, 12'h220, 32'h0, rd, err);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    cnt(c, p);
    chk("cpu ticks crystal", c, 6);
    // Amplifier and divider guards, then switchback with and without its enable.
    wr(MODE_A, 32'h48);
    rdc("amp off refused", MODE_A, 32'h40);
    wr(MODE_A, 32'h80);
    rdc("div 64", MODE_A, 32'h80);
    wr(MODE_A, 32'hC0);
    rdc("div jump refused", MODE_A, 32'h80);
    wr(MODE_A, 32'h40);
    wr(MODE_A, 32'h00);
    rdc("div reserved", MODE_A, 32'h40);
    wr(MODE_A, 32'hC0);
    pulse;
    rdc("no switchback", MODE_A, 32'hC0);
    wr(MODE_A, 32'h40);
    wr(MODE_A, 32'hE0);
    pulse;
    rdc("switchback", MODE_A, 32'h60);
    rdc("switchback source", EXT_A, 32'h08);
    // Crystal to ring, amplifier off, warm-up and return.
    // The slow instruction cycle left by the divide-by-64 test has to end before the source can flip.
    repeat (140) @(posedge core_clk);
    wr(EXT_A, 32'h00);
    repeat (12) @(posedge core_clk);
    rdc("ring active", EXT_A, 32'h04);
    cnt(c, p);
    chk("cpu ticks ring", c, 4);
    chk("instr cycles ring", ic, 1);
    wr(MODE_A, 32'h48);
    rdc("amp off taken", MODE_A, 32'h48);
    rdc("ready cleared", STAT_A, 32'h00);
    chk("amp pin off", crystalAmpEnable, 1'b0);
    wr(EXT_A, 32'h08);
    rdc("select amp off", EXT_A, 32'h04);
    wr(MODE_A, 32'h40);
    wr(EXT_A, 32'h08);
    rdc("select not ready", EXT_A, 32'h04);
    rdc("warming", STAT_A, 32'h00);
    repeat (2 * WARM + 4) @(posedge core_clk);
    rdc("ready set", STAT_A, 32'h10);
    wr(EXT_A, 32'h08);
    repeat (12) @(posedge core_clk);
    rdc("back on crystal", EXT_A, 32'h08);
    // Idle, then Stop with its wake sources.
    wr(PWR_A, 32'h01);
    @(negedge core_clk);
    chk("idle", sleepIdle, 1'b1);
    cnt(c, p);
    chk("idle cpu", c, 0);
    chk("idle periph", p, 6);
    wake(4'h8);
    chk("idle wake", sleepIdle, 1'b0);
    wr(PWR_A, 32'h02);
    @(negedge core_clk);
    chk("stop", sleepStop, 1'b1);
    chk("stop bandgap", bandgapEnable, 1'b0);
    chk("stop amp", crystalAmpEnable, 1'b0);
    cnt(c, p);
    chk("stop clocks", c + p, 0);
    wake(4'h8);
    chk("internal no wake", sleepStop, 1'b1);
    wake(4'h1);
    chk("pfi no bandgap", sleepStop, 1'b1);
    wake(4'h2);
    chk("rtc wake", sleepStop, 1'b0);
    repeat (2 * WARM + 8) @(posedge core_clk);
    cnt(c, p);
    chk("crystal restart", c, 6);
    wr(EXT_A, 32'h09);
    wr(PWR_A, 32'h02);
    @(negedge core_clk);
    chk("stop bandgap kept", bandgapEnable, 1'b1);
    wake(4'h1);
    chk("pfi wake", sleepStop, 1'b0);
    repeat (2 * WARM + 8) @(posedge core_clk);
    wr(EXT_A, 32'h0A);
    wr(PWR_A, 32'h02);
    wake(4'h4);
    rdc("ring start", EXT_A, 32'h06);
    cnt(c, p);
    chk("ring start ticks", c, 4);
    repeat (2 * WARM + 10) @(posedge core_clk);
    rdc("auto crystal", EXT_A, 32'h0A);
    // A second reset in mid-run must bring every field home.
    wr(MODE_A, 32'hE0);
    doReset;
    resetChk;
    endSim;
  end

  // The sequence takes about six hundred cycles; more than thirty times that means a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    endSim;
  end
endmodule : test_clock_source_and_sleep_control
`default_nettype wire
